// ---- core/sfq_map.vh ----
/*
 * Constants for the serial flash security-register, identifier and
 * quad-command-mode instruction block: opcodes, address fields, parameter
 * field positions, reset values and fixed dummy counts.
 * Assumes it is included by bare name from the design files of this block.
 */
`ifndef SFQ_MAP_VH
`define SFQ_MAP_VH

// Instruction opcodes handled here.
`define SFQ_OP_SECREG_RD 8'h48
`define SFQ_OP_ID_DUAL 8'h92
`define SFQ_OP_UNIQUE_ID 8'h4B
`define SFQ_OP_SET_PARAM 8'hC0
`define SFQ_OP_SET_WRAP 8'h77
`define SFQ_OP_BURST_WRAP 8'h0C
`define SFQ_OP_ENTER_QUAD 8'h38
`define SFQ_OP_EXIT_QUAD 8'hFF

// Security register selectors in address bits 15 to 8.
`define SFQ_SECREG1_SEL 8'h10
`define SFQ_SECREG2_SEL 8'h20
`define SFQ_SECREG3_SEL 8'h30
`define SFQ_SECREG_UPPER 8'h00

// Phase lengths, in received bits or in link clocks.
`define SFQ_OPC_BITS 6'h08
`define SFQ_ADDR_BITS 6'h18
`define SFQ_PARAM_BITS 6'h08
`define SFQ_WRAP_CMD_BITS 6'h20
`define SFQ_SECREG_DUMMY 6'h08
`define SFQ_ID_MODE_CLKS 6'h04
`define SFQ_UID_DUMMY 6'h20

// Read parameter byte field positions.
`define SFQ_DUMMY_HI 5
`define SFQ_DUMMY_LO 4
`define SFQ_WRAP_HI 1
`define SFQ_WRAP_LO 0
`define SFQ_SPI_WRAP_HI 6
`define SFQ_SPI_WRAP_LO 5

// Reset values: 8-byte wrap and 4 dummy clocks.
`define SFQ_WRAP_RST 2'h0
`define SFQ_DUMMY_RST 2'h0

// Dummy clock counts produced by the dummy-count field.
`define SFQ_DUMMY_4 6'h04
`define SFQ_DUMMY_6 6'h06
`define SFQ_DUMMY_8 6'h08

// Fixed dummy clocks of a fast read outside quad command mode.
`define SFQ_FIXED_FAST_DUMMY 6'h08

`endif

// ---- core/sfq_sync.v ----
/*
 * Two flip-flop synchroniser for a group of pin inputs.
 * Assumes every input is asynchronous to i_clock and that each bit may
 * be sampled independently; RST_VAL gives the idle level of each bit.
 */
`timescale 1ns/100ps
`default_nettype none

module sfq_sync #(
    parameter integer W = 6,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire i_clock,
    input wire i_rst,
    input wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);

    ////////////////////////////////////////////////////////////////////
    // One two-stage chain per bit; the first stage feeds only the second.
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg meta_q; // First stage, may go metastable.
            reg sync_q; // Second stage, safe to use.

            // Reset loads the idle level so no false edge follows release.
            always @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    meta_q <= RST_VAL[g];
                    sync_q <= RST_VAL[g];
                end else begin
                    meta_q <= i_async[g];
                    sync_q <= meta_q;
                end
            end

            assign o_sync[g] = sync_q;
        end
    endgenerate

endmodule

`default_nettype wire

// ---- core/sfq_cmd_core.v ----
/*
 * Instruction interpreter for the serial flash security-register read,
 * dual-I/O identifier read, unique number read, read parameter setting,
 * wrapped burst read and quad command mode entry and exit.
 * Assumes the host drives the link clock and chip select, the link clock
 * is well below a quarter of i_clock, the main array answers
 * i_array_data combinationally for o_array_addr, and quad enable and the
 * reset instruction come from other logic on i_clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sfq_map.vh"

// Summary of operation
// - 48h, 24-bit address, eight dummy clocks, data
// - Opcode and address sampled on rising clock
// - Security data out on falling edge, MSB first
// - Address 10h/20h/30h selects register; else undefined
// - Byte address increments, wraps FFh to 00h
// - 92h takes address two bits per clock
// - Manufacturer then device code, alternating, dual
// - 4Bh, four dummy bytes, 64-bit unique number
// - C0h accepted only in quad command mode
// - SPI wrap from 77h bits 6-5, kept
// - Reset defaults: wrap 8 bytes, 4 dummies
// - Dummy field: 00/01=4, 10=6, 11=8
// - Wrap field: 8, 16, 32, 64 bytes
// - Programmed dummies only for quad 0Bh/EBh/0Ch
// - 0Ch wraps inside aligned wrap window
// - 38h enters quad only with quad enable
// - Power-up in standard mode; modes exclusive
// - FFh in quad mode returns to standard
// - Mode switch keeps latch, suspend, wrap length
module sfq_cmd_core #(
    parameter [7:0] MFR_ID = 8'hA5,            // Arbitrary value.
    parameter [7:0] DEV_ID = 8'h5A,            // Arbitrary value.
    parameter [63:0] UNIQUE_ID = 64'h0123456789ABCDEF // Arbitrary value.
) (
    input wire i_clock,
    input wire i_rst,
    input wire i_link_clock,
    input wire i_cs_n,
    input wire [3:0] i_io,
    output reg [3:0] o_io,
    output reg [3:0] o_io_oe,
    input wire i_quad_enable_bit,
    input wire i_reset_instr,
    input wire i_secreg_wr,
    input wire [9:0] i_secreg_waddr,
    input wire [7:0] i_secreg_wdata,
    output wire [23:0] o_array_addr,
    output wire o_array_rd,
    input wire [7:0] i_array_data,
    output wire o_quad_command_mode,
    output wire [1:0] o_dummy_count_field,
    output wire [1:0] o_wrap_length_field,
    output wire [5:0] o_read_dummy_clocks
);

    ////////////////////////////////////////////////////////////////////
    // States of the frame sequencer.
    localparam [2:0] ST_OPC = 3'h0;   // Collecting the opcode.
    localparam [2:0] ST_ADDR = 3'h1;  // Collecting address or argument.
    localparam [2:0] ST_DUMMY = 3'h2; // Counting dummy clocks.
    localparam [2:0] ST_DATA = 3'h3;  // Driving data out.
    localparam [2:0] ST_DONE = 3'h4;  // Waiting for chip select to rise.
    localparam [2:0] ST_IGN = 3'h5;   // Unsupported; ignore the frame.

    ////////////////////////////////////////////////////////////////////
    // Functions.

    // Dummy clocks given by the dummy-count field.
    function [5:0] dummy_clocks;
        input [1:0] field;
        begin
            case (field)
                2'h2: dummy_clocks = `SFQ_DUMMY_6;
                2'h3: dummy_clocks = `SFQ_DUMMY_8;
                default: dummy_clocks = `SFQ_DUMMY_4;
            endcase
        end
    endfunction

    // Low-address mask of the wrap window given by the wrap-length field.
    function [5:0] wrap_mask;
        input [1:0] field;
        begin
            case (field)
                2'h1: wrap_mask = 6'h0F;
                2'h2: wrap_mask = 6'h1F;
                2'h3: wrap_mask = 6'h3F;
                default: wrap_mask = 6'h07;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisation; every link pin is sampled by i_clock.
    wire [5:0] pins_s; // {cs_n, link clock, io3..io0} after two flops.

    sfq_sync #(
        .W(6),
        .RST_VAL(6'h20)
    ) u_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async({i_cs_n, i_link_clock, i_io}),
        .o_sync(pins_s)
    );

    wire cs_n_s = pins_s[5];  // Chip select, active low.
    wire sclk_s = pins_s[4];  // Link clock.
    wire [3:0] io_s = pins_s[3:0]; // Data lines.

    reg sclk_d_q; // Link clock one cycle ago, for edge finding.
    reg cs_d_q;   // Chip select one cycle ago, for edge finding.

    // Edge detection is done on the second stage only.
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sclk_d_q <= 1'b0;
            cs_d_q <= 1'b1;
        end else begin
            sclk_d_q <= sclk_s;
            cs_d_q <= cs_n_s;
        end
    end

    wire active = ~cs_n_s;                          // Frame under way.
    wire sclk_rise = active & sclk_s & ~sclk_d_q;   // Host samples us here.
    wire sclk_fall = active & ~sclk_s & sclk_d_q;   // We change data here.
    wire cs_rise = cs_n_s & ~cs_d_q;                // End of a frame.

    ////////////////////////////////////////////////////////////////////
    // Sequencer and configuration state.
    reg [2:0] state_q;     // Frame sequencer state.
    reg [7:0] op_q;        // Opcode of the current frame.
    reg [31:0] sh_q;       // Input shift register.
    reg [5:0] bcnt_q;      // Bits received in the current phase.
    reg [5:0] dcnt_q;      // Dummy clocks counted.
    reg [5:0] dtgt_q;      // Dummy clocks required.
    reg [23:0] addr_q;     // Address, byte pointer or identifier index.
    reg [7:0] stage_q;     // Argument held until the frame ends.
    reg [7:0] obuf_q;      // Rest of the byte being sent.
    reg [3:0] ocnt_q;      // Bits of the byte still to send.
    reg quad_q;            // Quad command mode; clear means standard.
    reg [1:0] dummy_q;     // Dummy-count field.
    reg [1:0] wrap_q;      // Wrap-length field.

    // Three 256-byte security registers, filled by other logic.
    reg [7:0] sec_mem [0:767];

    // Loading port for the security registers.
    always @(posedge i_clock) begin
        if (i_secreg_wr && (i_secreg_waddr < 10'h300)) begin
            sec_mem[i_secreg_waddr] <= i_secreg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Lane widths on input and output.
    reg [2:0] in_lanes;  // Bits taken per rising edge.
    reg [2:0] out_lanes; // Bits driven per falling edge.

    // Quad mode uses four lines; 92h uses two after its opcode.
    always @* begin
        if (quad_q) begin
            in_lanes = 3'h4;
            out_lanes = 3'h4;
        end else if (op_q == `SFQ_OP_ID_DUAL && state_q != ST_OPC) begin
            in_lanes = 3'h2;
            out_lanes = 3'h2;
        end else begin
            in_lanes = 3'h1;
            out_lanes = 3'h1;
        end
    end

    reg [31:0] sh_nxt; // Shift register with this edge's bits added.

    // New bits enter at the bottom so the first bit ends up as the MSB.
    always @* begin
        case (in_lanes)
            3'h4: sh_nxt = {sh_q[27:0], io_s[3:0]};
            3'h2: sh_nxt = {sh_q[29:0], io_s[1], io_s[0]};
            default: sh_nxt = {sh_q[30:0], io_s[0]};
        endcase
    end

    wire [5:0] bcnt_nxt = bcnt_q + {3'h0, in_lanes};

    // Argument length after the opcode.
    wire [5:0] arg_bits = (op_q == `SFQ_OP_SET_WRAP) ? `SFQ_WRAP_CMD_BITS :
                          (op_q == `SFQ_OP_SET_PARAM) ? `SFQ_PARAM_BITS :
                          `SFQ_ADDR_BITS;

    ////////////////////////////////////////////////////////////////////
    // Byte source for the data phase.
    reg [7:0] src_byte; // Next byte to send.
    reg sec_ok;         // Address names a real security register.
    reg [1:0] sec_sel;  // Security register index.

    // Undefined upper-address values read back as all ones.
    always @* begin
        sec_ok = (addr_q[23:16] == `SFQ_SECREG_UPPER);
        case (addr_q[15:8])
            `SFQ_SECREG1_SEL: sec_sel = 2'h0;
            `SFQ_SECREG2_SEL: sec_sel = 2'h1;
            `SFQ_SECREG3_SEL: sec_sel = 2'h2;
            default: begin
                sec_sel = 2'h0;
                sec_ok = 1'b0;
            end
        endcase
        case (op_q)
            `SFQ_OP_SECREG_RD: src_byte = sec_ok ? sec_mem[{sec_sel, addr_q[7:0]}] : 8'hFF;
            `SFQ_OP_ID_DUAL: src_byte = addr_q[0] ? DEV_ID : MFR_ID;
            `SFQ_OP_UNIQUE_ID: src_byte = UNIQUE_ID[8 * (7 - addr_q[2:0]) +: 8];
            default: src_byte = i_array_data;
        endcase
    end

    // Next wrapped burst address: low bits turn over inside the window.
    wire [5:0] wmask = wrap_mask(wrap_q);
    wire [5:0] low_inc = addr_q[5:0] + 6'h01;
    wire [23:0] wrap_next = {addr_q[23:6], (addr_q[5:0] & ~wmask) | (low_inc & wmask)};

    reg [23:0] addr_adv; // Pointer after one byte has gone out.

    // Each reading instruction moves its pointer in its own way.
    always @* begin
        case (op_q)
            `SFQ_OP_SECREG_RD: addr_adv = {addr_q[23:8], addr_q[7:0] + 8'h01};
            `SFQ_OP_ID_DUAL: addr_adv = {addr_q[23:1], ~addr_q[0]};
            `SFQ_OP_UNIQUE_ID: addr_adv = {addr_q[23:3], addr_q[2:0] + 3'h1};
            default: addr_adv = wrap_next;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Frame sequencer. Input bits are taken on rising link clock edges
    // and output bits change on falling ones.
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_OPC;
            op_q <= 8'h00;
            sh_q <= 32'h00000000;
            bcnt_q <= 6'h00;
            dcnt_q <= 6'h00;
            dtgt_q <= 6'h00;
            addr_q <= 24'h000000;
            stage_q <= 8'h00;
            obuf_q <= 8'h00;
            ocnt_q <= 4'h0;
            o_io <= 4'h0;
            o_io_oe <= 4'h0;
        end else if (!active) begin
            // Between frames the sequencer idles and the lines float.
            state_q <= ST_OPC;
            bcnt_q <= 6'h00;
            dcnt_q <= 6'h00;
            ocnt_q <= 4'h0;
            o_io_oe <= 4'h0;
        end else if (sclk_rise) begin
            case (state_q)
                ST_OPC: begin
                    sh_q <= sh_nxt;
                    bcnt_q <= bcnt_nxt;
                    if (bcnt_nxt == `SFQ_OPC_BITS) begin
                        op_q <= sh_nxt[7:0];
                        bcnt_q <= 6'h00;
                        dcnt_q <= 6'h00;
                        addr_q <= 24'h000000;
                        case ({quad_q, sh_nxt[7:0]})
                            {1'b0, `SFQ_OP_SECREG_RD}: state_q <= ST_ADDR;
                            {1'b0, `SFQ_OP_ID_DUAL}: state_q <= ST_ADDR;
                            {1'b0, `SFQ_OP_SET_WRAP}: state_q <= ST_ADDR;
                            {1'b1, `SFQ_OP_SET_PARAM}: state_q <= ST_ADDR;
                            {1'b1, `SFQ_OP_BURST_WRAP}: state_q <= ST_ADDR;
                            {1'b0, `SFQ_OP_ENTER_QUAD}: state_q <= ST_DONE;
                            {1'b1, `SFQ_OP_EXIT_QUAD}: state_q <= ST_DONE;
                            {1'b0, `SFQ_OP_UNIQUE_ID}: begin
                                dtgt_q <= `SFQ_UID_DUMMY;
                                state_q <= ST_DUMMY;
                            end
                            default: state_q <= ST_IGN;
                        endcase
                    end
                end
                ST_ADDR: begin
                    sh_q <= sh_nxt;
                    bcnt_q <= bcnt_nxt;
                    if (bcnt_nxt == arg_bits) begin
                        addr_q <= sh_nxt[23:0];
                        stage_q <= sh_nxt[7:0];
                        case (op_q)
                            `SFQ_OP_SECREG_RD: begin
                                dtgt_q <= `SFQ_SECREG_DUMMY;
                                state_q <= ST_DUMMY;
                            end
                            `SFQ_OP_ID_DUAL: begin
                                // Mode bits arrive here and are not acted on.
                                dtgt_q <= `SFQ_ID_MODE_CLKS;
                                state_q <= ST_DUMMY;
                            end
                            `SFQ_OP_BURST_WRAP: begin
                                dtgt_q <= dummy_clocks(dummy_q);
                                state_q <= ST_DUMMY;
                            end
                            default: state_q <= ST_DONE;
                        endcase
                    end
                end
                ST_DUMMY: begin
                    dcnt_q <= dcnt_q + 6'h01;
                    if (dcnt_q + 6'h01 == dtgt_q) begin
                        state_q <= ST_DATA;
                        ocnt_q <= 4'h0;
                    end
                end
                ST_DONE: begin
                    // Extra clocks after a complete argument change nothing.
                    state_q <= ST_DONE;
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end else if (sclk_fall && state_q == ST_DATA) begin
            // Drive the top lanes of the byte, MSB first.
            if (ocnt_q == 4'h0) begin
                obuf_q <= src_byte << out_lanes;
                ocnt_q <= 4'h8 - {1'b0, out_lanes};
                addr_q <= addr_adv;
                o_io <= drive_bits(out_lanes, src_byte);
            end else begin
                obuf_q <= obuf_q << out_lanes;
                ocnt_q <= ocnt_q - {1'b0, out_lanes};
                o_io <= drive_bits(out_lanes, obuf_q);
            end
            o_io_oe <= drive_en(out_lanes);
        end
    end

    // Map the top bits of a byte onto the data lines.
    function [3:0] drive_bits;
        input [2:0] lanes;
        input [7:0] b;
        begin
            case (lanes)
                3'h4: drive_bits = b[7:4];
                3'h2: drive_bits = {2'h0, b[7:6]};
                default: drive_bits = {2'h0, b[7], 1'b0}; // Single output line.
            endcase
        end
    endfunction

    // Output enables for the lanes in use.
    function [3:0] drive_en;
        input [2:0] lanes;
        begin
            case (lanes)
                3'h4: drive_en = 4'hF;
                3'h2: drive_en = 4'h3;
                default: drive_en = 4'h2;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Mode and read parameter register. Apart from the reset instruction,
    // changes take effect only when chip select rises on a complete
    // instruction, so a frame cut short leaves the configuration alone.
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            quad_q <= 1'b0;
            dummy_q <= `SFQ_DUMMY_RST;
            wrap_q <= `SFQ_WRAP_RST;
        end else if (i_reset_instr) begin
            dummy_q <= `SFQ_DUMMY_RST;
            wrap_q <= `SFQ_WRAP_RST;
        end else if (cs_rise && state_q == ST_DONE) begin
            case ({quad_q, op_q})
                {1'b0, `SFQ_OP_ENTER_QUAD}: begin
                    // Only the mode flag moves; wrap length stays.
                    if (i_quad_enable_bit) begin
                        quad_q <= 1'b1;
                    end
                end
                {1'b1, `SFQ_OP_EXIT_QUAD}: begin
                    quad_q <= 1'b0;
                end
                {1'b1, `SFQ_OP_SET_PARAM}: begin
                    dummy_q <= stage_q[`SFQ_DUMMY_HI:`SFQ_DUMMY_LO];
                    wrap_q <= stage_q[`SFQ_WRAP_HI:`SFQ_WRAP_LO];
                end
                {1'b0, `SFQ_OP_SET_WRAP}: begin
                    wrap_q <= stage_q[`SFQ_SPI_WRAP_HI:`SFQ_SPI_WRAP_LO];
                end
                default: begin
                    quad_q <= quad_q;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs to the other read sequencers and the main array.
    assign o_quad_command_mode = quad_q;
    assign o_dummy_count_field = dummy_q;
    assign o_wrap_length_field = wrap_q;
    // Fast reads outside quad mode keep their fixed count.
    assign o_read_dummy_clocks = quad_q ? dummy_clocks(dummy_q) : `SFQ_FIXED_FAST_DUMMY;
    assign o_array_addr = addr_q;
    assign o_array_rd = (state_q == ST_DATA) && (op_q == `SFQ_OP_BURST_WRAP);

endmodule

`default_nettype wire

// ---- sim/sfq_host_model.sv ----
/* Host end of the link: drives clock, select and data lines.
   Assumes the bench resolves the data lines and feeds them back. */
`timescale 1ns/100ps
`default_nettype none
module sfq_host_model (
    output logic o_sck,
    output logic o_cs_n,
    output logic [3:0] o_io,
    input wire logic [3:0] i_io
);
    // The clock stands low outside frames.
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_io = 4'h0;
    end
    // One clock: data set while low, answer sampled just before the rise.
    task automatic clk(input logic [3:0] d, output logic [3:0] q);
        o_io = d;
        #38 q = i_io;
        #2 o_sck = 1'b1;
        #40 o_sck = 1'b0;
    endtask
    // Shifts n clocks of w bits, most significant first.
    task automatic send(input logic [63:0] v, input int n, input int w);
        logic [3:0] q;
        for (int i = n - 1; i >= 0; i--)
            clk(4'(v >> (i * w)) & 4'((1 << w) - 1), q);
    endtask
    // Released lines toggle, so a stale value never reads as an answer.
    task automatic recv(input int n, input int w, output logic [63:0] r);
        logic [3:0] q;
        r = 64'h0;
        for (int i = 0; i < n; i++) begin
            clk(~o_io, q);
            r = (r << w) | 64'(w == 1 ? 4'(q[1]) : q & 4'((1 << w) - 1));
        end
    endtask
    task automatic start();
        o_cs_n = 1'b0;
        #40;
    endtask
    // Select stays high long enough for the block to commit the frame.
    task automatic stop();
        #40 o_cs_n = 1'b1;
        #160;
    endtask
endmodule
`default_nettype wire

// ---- sim/sfq_cmd_core_checker.sv ----
/* Port checker for the instruction block.
   Assumes it is bound to sfq_cmd_core and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module sfq_cmd_core_checker (
    input wire i_clock,
    input wire i_rst,
    input wire i_cs_n,
    input wire i_quad_enable_bit,
    input wire i_reset_instr,
    input wire [3:0] o_io_oe,
    input wire o_array_rd,
    input wire o_quad_command_mode,
    input wire [1:0] o_dummy_count_field,
    input wire [1:0] o_wrap_length_field,
    input wire [5:0] o_read_dummy_clocks
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////
    property p_oe_idle; i_cs_n [*6] |-> o_io_oe == 4'h0; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("drive while deselected");
    property p_lanes; o_quad_command_mode ? o_io_oe inside {4'h0, 4'hF}
        : o_io_oe inside {4'h0, 4'h2, 4'h3}; endproperty
    a_lanes: assert property (p_lanes) else $error("lanes do not fit mode");
    // Decoded count follows its fields combinationally, in the same cycle.
    property p_dummy; $stable(o_dummy_count_field) && $stable(o_quad_command_mode)
        |-> o_read_dummy_clocks == (!o_quad_command_mode ? 6'h08
        : o_dummy_count_field == 2'h3 ? 6'h08
        : o_dummy_count_field == 2'h2 ? 6'h06 : 6'h04); endproperty
    a_dummy: assert property (p_dummy) else $error("dummy count decode");
    property p_rst_instr; i_reset_instr |-> ##[1:3]
        (o_wrap_length_field == 2'h0 && o_dummy_count_field == 2'h0); endproperty
    a_rst_instr: assert property (p_rst_instr) else $error("defaults not restored");
    property p_wrap_keep; $changed(o_quad_command_mode) |-> $stable(o_wrap_length_field);
    endproperty
    a_wrap_keep: assert property (p_wrap_keep) else $error("wrap lost on switch");
    property p_spi_param; !o_quad_command_mode && !$past(o_quad_command_mode)
        && !$past(i_reset_instr) && !$past(i_reset_instr, 2) && !$past(i_reset_instr, 3)
        |-> $stable(o_dummy_count_field); endproperty
    a_spi_param: assert property (p_spi_param) else $error("param set outside quad");
    property p_qe; $rose(o_quad_command_mode) |-> i_quad_enable_bit; endproperty
    a_qe: assert property (p_qe) else $error("quad entered without enable");
    property p_mode_hold; !i_cs_n [*6] |=> $stable(o_quad_command_mode); endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed in frame");
    property p_burst; o_array_rd |-> o_quad_command_mode; endproperty
    a_burst: assert property (p_burst) else $error("burst outside quad");
    c_quad: cover property ($rose(o_quad_command_mode));
    c_dual: cover property (o_io_oe == 4'h3);
    c_burst: cover property (o_array_rd);
endmodule
bind sfq_cmd_core sfq_cmd_core_checker u_chk (.i_clock(i_clock), .i_rst(i_rst),
    .i_cs_n(i_cs_n), .i_quad_enable_bit(i_quad_enable_bit), .i_reset_instr(i_reset_instr),
    .o_io_oe(o_io_oe), .o_array_rd(o_array_rd), .o_quad_command_mode(o_quad_command_mode),
    .o_dummy_count_field(o_dummy_count_field), .o_wrap_length_field(o_wrap_length_field),
    .o_read_dummy_clocks(o_read_dummy_clocks));
`default_nettype wire

// ---- sim/sfq_cmd_core_tb.sv ----
/* Self-checking bench: host model on the link, array and write port here.
   Assumes the default identity parameters of the block. */
`timescale 1ns/100ps
`default_nettype none
module sfq_cmd_core_tb;
    logic clk = 1'b0, rst = 1'b1, qe = 1'b0, rinst = 1'b0, swr = 1'b0;
    logic [9:0] swa = 10'h000;
    logic [7:0] swd = 8'h00;
    logic [63:0] r;
    wire sck, csn, ard, qm;
    wire [3:0] hio, dio, doe, io_w;
    wire [23:0] aaddr;
    wire [1:0] df, wf;
    wire [5:0] dck;
    int miscompares = 0, n_checks = 0;
    // Each line carries the block's level where it drives, else the host's.
    assign io_w = (doe & dio) | (~doe & hio);
    always #5 clk = ~clk;
    sfq_cmd_core u_dut (.i_clock(clk), .i_rst(rst), .i_link_clock(sck), .i_cs_n(csn),
        .i_io(io_w), .o_io(dio), .o_io_oe(doe), .i_quad_enable_bit(qe),
        .i_reset_instr(rinst), .i_secreg_wr(swr), .i_secreg_waddr(swa),
        .i_secreg_wdata(swd), .o_array_addr(aaddr), .o_array_rd(ard),
        .i_array_data(aaddr[7:0] ^ 8'h3C), .o_quad_command_mode(qm),
        .o_dummy_count_field(df), .o_wrap_length_field(wf), .o_read_dummy_clocks(dck));
    sfq_host_model u_host (.o_sck(sck), .o_cs_n(csn), .o_io(hio), .i_io(io_w));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic sync();
        @(posedge clk);
        #1;
    endtask
    // A write-only frame: no answer is expected back.
    task automatic frame(input logic [63:0] v, input int n, input int w);
        u_host.start();
        u_host.send(v, n, w);
        u_host.stop();
    endtask
    ////////////////////////////////////////////////////////////////
    // Bytes FE, FF, 00 of register two, read across the byte wrap.
    task automatic t_secreg();
        for (int b = 0; b < 3; b++) begin
            sync();
            swr = 1'b1;
            swa = {2'h1, 8'(8'hFE + b)};
            swd = 8'(8'hA0 + b);
        end
        sync();
        swr = 1'b0;
        u_host.start();
        u_host.send({8'h48, 24'h0020FE, 8'h00}, 40, 1);
        u_host.recv(24, 1, r);
        u_host.stop();
        chk("secreg read", 64'hA0A1A2, r);
        $display("test secreg done");
    endtask
    task automatic t_ident();
        u_host.start();
        u_host.send(64'h92, 8, 1);
        u_host.send({24'h000000, 8'hF0}, 16, 2);
        u_host.recv(16, 2, r);
        u_host.stop();
        chk("dual id", 64'hA55AA55A, r);
        u_host.start();
        u_host.send(64'h4B00000000, 40, 1);
        u_host.recv(64, 1, r);
        u_host.stop();
        chk("unique id", 64'h0123456789ABCDEF, r);
        $display("test ident done");
    endtask
    task automatic t_modes();
        frame({8'hC0, 8'h33}, 16, 1);
        chk("dummy field spi", 64'h0, 64'(df));
        chk("dummy clocks spi", 64'h8, 64'(dck));
        frame({8'h77, 24'h0, 8'h40}, 40, 1);
        chk("wrap field spi", 64'h2, 64'(wf));
        frame(64'h38, 8, 1);
        chk("mode no enable", 64'h0, 64'(qm));
        qe = 1'b1;
        frame(64'h38, 8, 1);
        chk("mode quad", 64'h1, 64'(qm));
        chk("wrap kept", 64'h2, 64'(wf));
        for (int f = 0; f < 4; f++) begin
            frame({8'hC0, 2'h0, 2'(f), 2'h0, 2'(3 - f)}, 4, 4);
            chk("dummy field", 64'(f), 64'(df));
            chk("wrap field", 64'(3 - f), 64'(wf));
            chk("dummy clocks", f == 3 ? 64'h8 : f == 2 ? 64'h6 : 64'h4, 64'(dck));
        end
        u_host.start();
        u_host.send({8'h0C, 24'h01010E, 32'h0}, 16, 4);
        u_host.recv(8, 4, r);
        u_host.stop();
        chk("burst wrap", 64'h32333435, r);
        frame(64'hFF, 2, 4);
        chk("mode spi", 64'h0, 64'(qm));
        chk("dummy kept", 64'h3, 64'(df));
        sync();
        rinst = 1'b1;
        sync();
        rinst = 1'b0;
        repeat (4) sync();
        chk("fields reset", 64'h0, 64'({df, wf}));
        $display("test modes done");
    endtask
    initial begin
        #400_000;
        miscompares++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        repeat (8) sync();
        t_secreg();
        t_ident();
        t_modes();
        final_report();
    end
endmodule
`default_nettype wire
